// >>> hdl/dprc_defs.svh
`ifndef DPRC_DEFS_SVH
`define DPRC_DEFS_SVH

// ****************************************
// control register field positions
// ****************************************
`define DPRC_BIT_PWRUP 3
`define DPRC_BIT_HOLD 2
`define DPRC_BIT_WARM 1
`define DPRC_BIT_NPD 0
`define DPRC_CTRL_USED_MSB 3

// ****************************************
// reset values
// ****************************************
`define DPRC_PWRUP_RST 1'h0
`define DPRC_HOLD_RST 1'h0
`define DPRC_NPD_RST 1'h0
`define DPRC_OSLOCK_RST 1'h1

// ****************************************
// lock key and self offset layout
// ****************************************
`define DPRC_OSLOCK_KEY 32'hC5ACCE55
`define DPRC_OFFSET_VALID 2'h3
`define DPRC_OFFSET_LSB 12
`define DPRC_OFFSET_MSB 39
`define DPRC_OFFSET_W 28
`define DPRC_SIGN_W 24
`define DPRC_SELF_OFFSET_DEF 28'h0001000

`endif

// >>> hdl/dprc_pkg.sv
`default_nettype none

package dprc_pkg;

  // access path that carries a register request
  typedef enum logic [2:0]
  {
    DPRC_PATH_MM = 3'h1,
    DPRC_PATH_EXT = 3'h2,
    DPRC_PATH_CP = 3'h4
  } dprc_path_t;

  // hold-in-reset sequencer states
  typedef enum logic [2:0]
  {
    DPRC_ST_RUN = 3'h1,
    DPRC_ST_RESET = 3'h2,
    DPRC_ST_HELD = 3'h4
  } dprc_state_t;

  // one register request, valid for one cycle
  typedef struct packed
  {
    logic valid;
    logic write;
    dprc_path_t path;
    logic sel_offset;
    logic dual;
    logic [31:0] wdata;
  } dprc_req_t;

  // read answer, one cycle after the request
  typedef struct packed
  {
    logic valid;
    logic [63:0] data;
  } dprc_rsp_t;

endpackage
`default_nettype wire

// >>> hdl/dprc_gate.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// lock gating for gated control bits
// ****************************************
module dprc_gate
  import dprc_pkg::*;
(
  // path and core state
  input wire dprc_path_t path,
  input wire logic core_powered,
  input wire logic double_lock_status,
  input wire logic os_lock_state,
  // verdicts
  output logic npd_blocked,
  output logic warm_blocked
);

  // the os lock only shuts out the external debugger
  always_comb
  begin
    npd_blocked = !core_powered || double_lock_status || (path == DPRC_PATH_EXT && os_lock_state);
    warm_blocked = (path != DPRC_PATH_CP) && npd_blocked;
  end

endmodule
`default_nettype wire

// >>> hdl/dprc_top.sv
// Behaviour
// - bit 3 drives power-up request output
// - bit 3 written only by memory/external paths
// - coprocessor path: bits 3:2 read zero, ignored
// - hold bit keeps non-debug logic in reset
// - hold bit resets to zero
// - writing 1 to bit 1 requests warm reset
// - warm bit reads unknown; locked writes ignored, except coprocessor-path writes, which are accepted
// - bit 0 drives no-power-down output, resets zero
// - bit 0 locked when powered down, double-locked
// - bit 0 cleared when core powers down
// - self offset: dual read 64, single 32
// - self offset only on coprocessor port
// - offset in 39:12, reserved 11:2, valid 1:0
// - valid field reads binary 11
// - os lock set at power-up, changed by writes
`timescale 1ns/100ps
`default_nettype none
`include "dprc_defs.svh"

module dprc_top
  import dprc_pkg::*;
#(
  parameter logic [`DPRC_OFFSET_W-1:0] SELF_OFFSET = `DPRC_SELF_OFFSET_DEF
)
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register access
  input wire dprc_req_t acc_req,
  output dprc_rsp_t acc_rsp,
  // lock access writes
  input wire logic os_lock_wr_valid,
  input wire logic [31:0] os_lock_wr_data,
  // core state
  input wire logic core_powered,
  input wire logic double_lock_status,
  input wire logic core_powerup_reset,
  input wire logic core_reset_in,
  // power controller and reset controller
  output logic powerup_request_out,
  output logic no_powerdown_out,
  output logic warm_reset_req_out,
  output logic nondebug_reset_out,
  output logic os_lock_state
);

  // ****************************************
  // decode
  // ****************************************
  logic hold_in_reset_bit;
  logic npd_blocked;
  logic warm_blocked;
  logic ctrl_wr;
  logic warm_accept;
  dprc_state_t state_reg;
  dprc_state_t state_next;

  dprc_gate u_gate
  (
    .path(acc_req.path),
    .core_powered(core_powered),
    .double_lock_status(double_lock_status),
    .os_lock_state(os_lock_state),
    .npd_blocked(npd_blocked),
    .warm_blocked(warm_blocked)
  );

  // writes to the offset register fall on the floor
  assign ctrl_wr = acc_req.valid && acc_req.write && !acc_req.sel_offset;
  assign warm_accept = ctrl_wr && acc_req.wdata[`DPRC_BIT_WARM] && !warm_blocked;

  // ****************************************
  // control bits
  // ****************************************
  // power-up request lives in the debug domain, so no power gating
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      powerup_request_out <= `DPRC_PWRUP_RST;
      hold_in_reset_bit <= `DPRC_HOLD_RST;
    end
    else if (ctrl_wr && acc_req.path != DPRC_PATH_CP)
    begin
      powerup_request_out <= acc_req.wdata[`DPRC_BIT_PWRUP];
      hold_in_reset_bit <= acc_req.wdata[`DPRC_BIT_HOLD];
    end
  end

  // no-power-down bit sits in the core domain and dies with it
  always_ff @(posedge clk)
  begin
    if (sys_rst || !core_powered)
      no_powerdown_out <= `DPRC_NPD_RST;
    else if (ctrl_wr && !npd_blocked)
      no_powerdown_out <= acc_req.wdata[`DPRC_BIT_NPD];
  end

  // warm reset holds no state, only a pulse per accepted write
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      warm_reset_req_out <= 1'h0;
    else
      warm_reset_req_out <= warm_accept;
  end

  // ****************************************
  // os lock
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (sys_rst || core_powerup_reset)
      os_lock_state <= `DPRC_OSLOCK_RST;
    else if (os_lock_wr_valid)
      os_lock_state <= (os_lock_wr_data == `DPRC_OSLOCK_KEY);
  end

  // ****************************************
  // hold-in-reset sequencer
  // ****************************************
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      DPRC_ST_RUN:
        if (core_reset_in)
          state_next = DPRC_ST_RESET;
      DPRC_ST_RESET:
        if (!core_reset_in)
          state_next = hold_in_reset_bit ? DPRC_ST_HELD : DPRC_ST_RUN;
      DPRC_ST_HELD:
        if (core_reset_in)
          state_next = DPRC_ST_RESET;
        else if (!hold_in_reset_bit)
          state_next = DPRC_ST_RUN;
      default:
        state_next = DPRC_ST_RESET;
    endcase
  end

  // output is registered with the state, so they never disagree
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_reg <= DPRC_ST_RUN;
      nondebug_reset_out <= 1'h0;
    end
    else
    begin
      state_reg <= state_next;
      nondebug_reset_out <= (state_next != DPRC_ST_RUN);
    end
  end

  // ****************************************
  // read path
  // ****************************************
  logic [63:0] rd_next;
  logic [`DPRC_CTRL_USED_MSB:0] ctrl_view;
  logic [63:0] offset_word;

  // sign-extended offset word, valid field hard-wired
  assign offset_word = {{`DPRC_SIGN_W{SELF_OFFSET[`DPRC_OFFSET_W-1]}}, SELF_OFFSET,
                        10'h000, `DPRC_OFFSET_VALID};

  always_comb
  begin
    ctrl_view = '0;
    // unknown reads are modelled as zero
    if (acc_req.path != DPRC_PATH_CP)
    begin
      ctrl_view[`DPRC_BIT_PWRUP] = powerup_request_out;
      ctrl_view[`DPRC_BIT_HOLD] = hold_in_reset_bit;
    end
    ctrl_view[`DPRC_BIT_WARM] = 1'h0;
    ctrl_view[`DPRC_BIT_NPD] = no_powerdown_out && !npd_blocked;
    rd_next = '0;
    if (!acc_req.sel_offset)
      rd_next = {60'h0, ctrl_view};
    else if (acc_req.path == DPRC_PATH_CP)
      rd_next = acc_req.dual ? offset_word : {32'h0, offset_word[31:0]};
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      acc_rsp <= '0;
    else
    begin
      acc_rsp.valid <= acc_req.valid && !acc_req.write;
      acc_rsp.data <= (acc_req.valid && !acc_req.write) ? rd_next : 64'h0;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  dprc_req_t req_prev;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      req_prev <= '0;
    else
      req_prev <= acc_req;
  end

  pwrup_drive_a: assert property (ctrl_wr && acc_req.path != DPRC_PATH_CP |=>
    powerup_request_out == $past(acc_req.wdata[`DPRC_BIT_PWRUP])) else $error("powerup request mismatch");
  cp_ignore_a: assert property (ctrl_wr && acc_req.path == DPRC_PATH_CP |=> $stable(powerup_request_out))
    else $error("coprocessor write changed powerup bit");
  hold_keep_a: assert property (state_reg == DPRC_ST_HELD && hold_in_reset_bit |=> nondebug_reset_out)
    else $error("held reset released early");
  hold_free_a: assert property (!hold_in_reset_bit && !core_reset_in ##1 !core_reset_in |->
    ##1 !nondebug_reset_out) else $error("reset not released");
  warm_pulse_a: assert property (warm_reset_req_out |-> $past(warm_accept))
    else $error("warm pulse without write");
  warm_lock_a: assert property (ctrl_wr && acc_req.path == DPRC_PATH_EXT && os_lock_state |=>
    !warm_reset_req_out) else $error("locked warm write accepted");
  npd_lock_a: assert property (double_lock_status && !no_powerdown_out |=> !no_powerdown_out)
    else $error("double lock ignored");
  npd_lost_a: assert property (!core_powered |=> !no_powerdown_out)
    else $error("no-powerdown kept through power down");
  npd_drive_a: assert property (ctrl_wr && !npd_blocked && core_powered ##1 core_powered |->
    no_powerdown_out == $past(acc_req.wdata[`DPRC_BIT_NPD])) else $error("no-powerdown mismatch");
  rsvd_zero_a: assert property (acc_rsp.valid && !req_prev.sel_offset |-> acc_rsp.data[63:4] == 60'h0)
    else $error("reserved bits nonzero");
  offset_valid_a: assert property (acc_rsp.valid && req_prev.sel_offset && req_prev.path == DPRC_PATH_CP |->
    acc_rsp.data[1:0] == `DPRC_OFFSET_VALID) else $error("valid field wrong");
  offset_view_a: assert property (acc_rsp.valid && req_prev.sel_offset && !req_prev.dual |->
    acc_rsp.data[63:32] == 32'h0) else $error("single-word view too wide");
  offset_mm_a: assert property (acc_rsp.valid && req_prev.sel_offset && req_prev.path != DPRC_PATH_CP |->
    acc_rsp.data == 64'h0) else $error("offset visible off coprocessor");
  oslock_por_a: assert property (core_powerup_reset |=> os_lock_state)
    else $error("os lock not set at power-up");

  warm_seen_c: cover property (warm_reset_req_out);
  held_seen_c: cover property (state_reg == DPRC_ST_HELD ##1 state_reg == DPRC_ST_RUN);
  npd_seen_c: cover property (no_powerdown_out ##1 !core_powered);
  dual_seen_c: cover property (acc_rsp.valid && req_prev.dual && req_prev.sel_offset);

endmodule
`default_nettype wire

// >>> bench/dprc_pwr_model.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// system power controller model
// ****************************************
module dprc_pwr_model (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // device requests
  input wire logic powerup_request_out,
  input wire logic no_powerdown_out,
  // bench controls: handshake and abrupt loss
  input wire logic pd_req,
  input wire logic cut,
  // core power state
  output logic core_powered
);
  // cut wins so a loss can be shown even in emulate mode
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      core_powered <= 1'h1;
    else if (cut)
      core_powered <= 1'h0;
    else if (powerup_request_out)
      core_powered <= 1'h1;
    else if (pd_req && !no_powerdown_out)
      core_powered <= 1'h0;
  end
endmodule

`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top
  import dprc_pkg::*;
;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  dprc_req_t acc_req = '0;
  dprc_rsp_t acc_rsp;
  logic lk_v = 1'h0;
  logic [31:0] lk_d = '0;
  logic dbl = 1'h0;
  logic pur = 1'h0;
  logic cri = 1'h0;
  logic pd_req = 1'h0;
  logic cut = 1'h0;
  logic pwr, pup, npd, warm, nd, osl;
  int error_cnt = 0;
  int checks_done = 0;
  int n;

  // ****************************************
  // clock, device and power controller
  // ****************************************
  always #20 clk = ~clk;

  dprc_top #(.SELF_OFFSET(28'h8000123)) i_dut (.clk(clk), .sys_rst(sys_rst),
    .acc_req(acc_req), .acc_rsp(acc_rsp), .os_lock_wr_valid(lk_v), .os_lock_wr_data(lk_d),
    .core_powered(pwr), .double_lock_status(dbl), .core_powerup_reset(pur), .core_reset_in(cri),
    .powerup_request_out(pup), .no_powerdown_out(npd), .warm_reset_req_out(warm),
    .nondebug_reset_out(nd), .os_lock_state(osl));

  dprc_pwr_model i_pwr (.clk(clk), .sys_rst(sys_rst), .powerup_request_out(pup),
    .no_powerdown_out(npd), .pd_req(pd_req), .cut(cut), .core_powered(pwr));

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one-cycle request; returns just after the taking edge
  task automatic acc(input logic w, input dprc_path_t p, input logic so, input logic du,
    input logic [31:0] d);
    @(posedge clk);
    acc_req <= '{1'h1, w, p, so, du, d};
    @(posedge clk);
    acc_req <= '0;
    #1;
  endtask

  task automatic rd(input dprc_path_t p, input logic so, input logic du, input logic [63:0] e);
    acc(1'b0, p, so, du, 32'h0);
    chk(acc_rsp.valid, 1);
    chk(acc_rsp.data, e);
  endtask

  // one-cycle strobe: 0 core reset, 1 lock write with data, 2 power-up reset
  task automatic pulse(input int sel, input logic [31:0] d);
    @(posedge clk);
    case (sel)
      0: cri <= 1'h1;
      1:
      begin
        lk_v <= 1'h1;
        lk_d <= d;
      end
      default: pur <= 1'h1;
    endcase
    @(posedge clk);
    cri <= 1'h0;
    lk_v <= 1'h0;
    pur <= 1'h0;
    #1;
  endtask

  task automatic done(input string t);
    $display("test %s done", t);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // watchdog keeps a hang from running forever
  initial
  begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    #1;
    chk({pup, npd, warm, nd, osl}, 64'h01);
    chk(acc_rsp.valid, 64'h0);
    chk(acc_rsp.data, 64'h0);
    done("reset");
    acc(1'h1, DPRC_PATH_MM, 1'h0, 1'h0, 32'hFFFFFFFF);
    chk({pup, npd, warm}, 64'h7);
    @(posedge clk);
    #1;
    chk(warm, 64'h0);
    rd(DPRC_PATH_MM, 1'h0, 1'h0, 64'hD);
    rd(DPRC_PATH_CP, 1'h0, 1'h0, 64'h1);
    acc(1'h1, DPRC_PATH_CP, 1'h0, 1'h0, 32'h0);
    chk({pup, npd, warm}, 64'h4);
    rd(DPRC_PATH_MM, 1'h0, 1'h0, 64'hC);
    done("paths");
    // hold bit set: stays in reset until cleared
    pulse(0, 32'h0);
    @(posedge clk);
    #1;
    chk(nd, 64'h1);
    acc(1'h1, DPRC_PATH_MM, 1'h0, 1'h0, 32'h8);
    // the sequencer sees the cleared bit one edge after it lands
    chk(nd, 64'h1);
    @(posedge clk);
    #1;
    chk(nd, 64'h0);
    pulse(0, 32'h0);
    @(posedge clk);
    #1;
    chk(nd, 64'h0);
    done("hold");
    acc(1'h1, DPRC_PATH_EXT, 1'h0, 1'h0, 32'h3);
    chk({npd, warm}, 64'h0);
    pulse(1, 32'h0);
    chk(osl, 64'h0);
    // warm requests go through the external port, as software is told to
    acc(1'h1, DPRC_PATH_EXT, 1'h0, 1'h0, 32'h3);
    chk({npd, warm}, 64'h3);
    @(posedge clk);
    dbl <= 1'h1;
    acc(1'h1, DPRC_PATH_MM, 1'h0, 1'h0, 32'h2);
    chk({npd, warm}, 64'h2);
    // output still high, but the locked bit must read back as zero
    rd(DPRC_PATH_MM, 1'h0, 1'h0, 64'h0);
    // deprecated coprocessor write, used a second time to show it still works under double lock
    acc(1'h1, DPRC_PATH_CP, 1'h0, 1'h0, 32'h2);
    chk({npd, warm}, 64'h3);
    @(posedge clk);
    dbl <= 1'h0;
    done("locks");
    // emulate mode survives a power-down handshake
    acc(1'h1, DPRC_PATH_MM, 1'h0, 1'h0, 32'h1);
    @(posedge clk);
    pd_req <= 1'h1;
    repeat (4) @(posedge clk);
    #1;
    chk(pwr, 64'h1);
    @(posedge clk);
    cut <= 1'h1;
    n = 0;
    while (pwr !== 1'h0)
    begin
      @(posedge clk);
      #1;
      n++;
      if (n > 8)
      begin
        error_cnt++;
        wrap_up();
      end
    end
    @(posedge clk);
    #1;
    chk(npd, 64'h0);
    acc(1'h1, DPRC_PATH_MM, 1'h0, 1'h0, 32'h1);
    chk(npd, 64'h0);
    @(posedge clk);
    cut <= 1'h0;
    pd_req <= 1'h0;
    acc(1'h1, DPRC_PATH_MM, 1'h0, 1'h0, 32'h8);
    repeat (2) @(posedge clk);
    #1;
    chk({pup, pwr}, 64'h3);
    done("power");
    rd(DPRC_PATH_CP, 1'h1, 1'h1, {{24{1'h1}}, 28'h8000123, 12'h003});
    rd(DPRC_PATH_CP, 1'h1, 1'h0, {32'h0, 20'h00123, 12'h003});
    rd(DPRC_PATH_MM, 1'h1, 1'h0, 64'h0);
    done("offset");
    pulse(1, 32'hC5ACCE55);
    chk(osl, 64'h1);
    pulse(1, 32'h1);
    chk(osl, 64'h0);
    pulse(2, 32'h0);
    chk(osl, 64'h1);
    done("oslock");
    wrap_up();
  end
endmodule

`default_nettype wire
